// ---- hw/smfe_host.sv ----
`timescale 1ns/1ps
`include "smfe_defines.svh"
module smfe_host
  import smfe_pkg::*;
#(
  parameter int SCK_HALF = 4,
  parameter bit SPI_MODE3 = 1'b0,
  parameter int PWRUP_CYC = `SMFE_PWRUP_US * `SMFE_CLK_MHZ,
  parameter int DPD_EXIT_CYC = `SMFE_DPD_EXIT_US * `SMFE_CLK_MHZ,
  parameter int HIB_EXIT_CYC = `SMFE_HIB_EXIT_US * `SMFE_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [`SMFE_BYTE_BITS-1:0] cmd,
  input wire smfe_lane_t lane_mode,
  input wire logic has_addr,
  input wire logic [`SMFE_ADDR_BITS-1:0] addr,
  input wire logic send_mode_byte,
  input wire logic [`SMFE_BYTE_BITS-1:0] mode_byte,
  input wire logic [`SMFE_DUM_W-1:0] dummy_cyc,
  input wire logic [`SMFE_NB_W-1:0] nbytes,
  input wire logic is_read,
  input wire smfe_pwr_t pwr_op,
  input wire logic wp_level,
  input wire logic [`SMFE_BYTE_BITS-1:0] wr_byte,
  output logic busy,
  output logic wr_take,
  output logic rd_valid,
  output logic [`SMFE_BYTE_BITS-1:0] rd_byte,
  output logic xip_active,
  output logic asleep,
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [3:0] io_in
);
  localparam int CW = `SMFE_CNT_W;
  localparam int ENTER_CYC = (`SMFE_ENTER_US * `SMFE_CLK_MHZ);
  localparam int CS_HI_CYC = (`SMFE_CS_HI_NS + `SMFE_CLK_NS - 1) / `SMFE_CLK_NS;

  // Read data crosses a two-flop synchroniser, so half a clock must cover it
  if (SCK_HALF < 4) begin : g_bad_half
    $error("SCK_HALF must be at least 4");
  end
  if (PWRUP_CYC < 1 || DPD_EXIT_CYC < 1 || HIB_EXIT_CYC < 1 ||
      PWRUP_CYC >= (1 << CW) || DPD_EXIT_CYC >= (1 << CW) || HIB_EXIT_CYC >= (1 << CW))
  begin : g_bad_cnt
    $error("wait counts must fit the wait counter");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  smfe_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [`SMFE_BITS_W-1:0] bits_r, bits_nxt;
  logic [`SMFE_SR_W-1:0] sh_r, sh_nxt;
  logic [`SMFE_BYTE_BITS-1:0] rx_r, rx_nxt;
  logic [`SMFE_BYTE_BITS-1:0] cmd_r, cmd_nxt, mb_r, mb_nxt;
  logic [`SMFE_BYTE_BITS-1:0] rd_byte_r, rd_byte_nxt;
  logic [`SMFE_ADDR_BITS-1:0] addr_r, addr_nxt;
  logic [`SMFE_DUM_W-1:0] dum_r, dum_nxt;
  logic [`SMFE_NB_W-1:0] nb_r, nb_nxt;
  smfe_lane_t mode_r, mode_nxt;
  smfe_pwr_t pop_r, pop_nxt, sleep_r, sleep_nxt;
  logic has_addr_r, has_addr_nxt, mb_en_r, mb_en_nxt, rd_r, rd_nxt;
  logic xip_r, xip_nxt, cs_n_r, cs_n_nxt;
  logic wr_take_r, wr_take_nxt, rd_valid_r, rd_valid_nxt, busy_r;
  logic [3:0] io_out_r, io_oe_r;
  logic asleep_r;
  logic [3:0] io_s1_r, io_s2_r;
  logic enter;
  smfe_state_t ent;
  logic rise_evt, sck_idle;

  // Two flops per lane before anything looks at the pins
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        io_s1_r[i] <= 1'b0;
        io_s2_r[i] <= 1'b0;
      end else begin
        io_s1_r[i] <= io_in[i];
        io_s2_r[i] <= io_s1_r[i];
      end
    end
  end

  // Clock runs only inside the shifting phases
  wire run_w = (st_r == ST_CMD) || (st_r == ST_ADDR) || (st_r == ST_XBYTE) ||
               (st_r == ST_DUMMY) || (st_r == ST_DATA);

  smfe_sck_gen #(
    .HALF(SCK_HALF),
    .MODE3(SPI_MODE3)
  ) u_sck (
    .clk(clk),
    .nrst(nrst),
    .run(run_w),
    .sck(sck),
    .rise_evt(rise_evt),
    .sck_idle(sck_idle)
  );

  // Lane width and shift steps of the current component
  wire smfe_comp_t comp_cur = (st_r == ST_CMD) ? CP_CMD : (st_r == ST_DATA) ? CP_DATA : CP_ADDR;
  wire [2:0] w_cur = (st_r == ST_DUMMY) ? 3'h1 : smfe_lane_w(mode_r, comp_cur);
  wire last_bit = (bits_r <= {3'h0, w_cur});
  wire [`SMFE_SR_W-1:0] sh_step = sh_r << w_cur;
  wire [`SMFE_BYTE_BITS-1:0] rx_shift = (w_cur == 3'h4) ? {rx_r[3:0], io_s2_r} :
                                        (w_cur == 3'h2) ? {rx_r[5:0], io_s2_r[1:0]} :
                                        {rx_r[6:0], io_s2_r[1]};

  // Phase sequence after each component; absent parts are skipped
  wire smfe_state_t ph_after_dum = (nb_r != '0) ? ST_DATA : ST_DONE;
  wire smfe_state_t ph_after_xb = (dum_r != '0) ? ST_DUMMY : ph_after_dum;
  wire smfe_state_t ph_after_addr = mb_en_r ? ST_XBYTE : ph_after_xb;
  wire smfe_state_t ph_after_cmd = has_addr_r ? ST_ADDR : ph_after_addr;
  wire smfe_state_t ph_first = xip_r ? ph_after_cmd : ST_CMD;

  // Pin drive: host lanes follow the shift register, read phases float
  wire tx_active = (st_r == ST_CMD) || (st_r == ST_ADDR) || (st_r == ST_XBYTE) ||
                   ((st_r == ST_DATA) && !rd_r);
  wire [3:0] lane_mask = (w_cur == 3'h4) ? 4'hF : (w_cur == 3'h2) ? 4'h3 : 4'h1;
  wire [3:0] tx_bits = (w_cur == 3'h4) ? sh_r[31:28] :
                       (w_cur == 3'h2) ? {2'h0, sh_r[31:30]} : {3'h0, sh_r[31]};
  wire wp_lane = (mode_r == LM_111);
  wire [3:0] oe_nxt = (tx_active ? lane_mask : 4'h0) | (wp_lane ? 4'h4 : 4'h0);
  wire [3:0] out_nxt = (tx_active ? tx_bits : 4'h0) | (wp_lane ? {1'b0, wp_level, 2'h0} : 4'h0);

  // Sequencer; the phase loader at the bottom fills the shifter on entry
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    cmd_nxt = cmd_r;
    mb_nxt = mb_r;
    addr_nxt = addr_r;
    dum_nxt = dum_r;
    nb_nxt = nb_r;
    mode_nxt = mode_r;
    pop_nxt = pop_r;
    sleep_nxt = sleep_r;
    has_addr_nxt = has_addr_r;
    mb_en_nxt = mb_en_r;
    rd_nxt = rd_r;
    xip_nxt = xip_r;
    cs_n_nxt = cs_n_r;
    wr_take_nxt = 1'b0;
    rd_valid_nxt = 1'b0;
    rd_byte_nxt = rd_byte_r;
    enter = 1'b0;
    ent = ST_DONE;
    unique case (st_r)
      ST_PWRUP: begin
        if (cnt_r == '0) st_nxt = ST_IDLE;
        else cnt_nxt = cnt_r - CW'(1);
      end
      ST_IDLE: begin
        cs_n_nxt = 1'b1;
        if (start) begin
          cmd_nxt = cmd;
          mode_nxt = lane_mode;
          addr_nxt = addr;
          has_addr_nxt = has_addr;
          mb_en_nxt = send_mode_byte && has_addr;
          mb_nxt = mode_byte;
          dum_nxt = dummy_cyc;
          nb_nxt = nbytes;
          rd_nxt = is_read;
          pop_nxt = pwr_op;
          cs_n_nxt = 1'b0;
          cnt_nxt = CW'(SCK_HALF - 1);
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r == '0) begin
          enter = 1'b1;
          ent = ph_first;
        end else begin
          cnt_nxt = cnt_r - CW'(1);
        end
      end
      ST_CMD, ST_ADDR, ST_XBYTE, ST_DUMMY: begin
        if (rise_evt) begin
          bits_nxt = bits_r - {3'h0, w_cur};
          sh_nxt = sh_step;
          if (last_bit) begin
            enter = 1'b1;
            ent = (st_r == ST_CMD) ? ph_after_cmd : (st_r == ST_ADDR) ? ph_after_addr :
                  (st_r == ST_XBYTE) ? ph_after_xb : ph_after_dum;
            if (st_r == ST_XBYTE && mb_r[7:4] == `SMFE_XIP_ON) xip_nxt = 1'b1;
            if (st_r == ST_XBYTE && mb_r[7:4] == `SMFE_XIP_OFF) xip_nxt = 1'b0;
          end
        end
      end
      ST_DATA: begin
        if (rise_evt) begin
          bits_nxt = bits_r - {3'h0, w_cur};
          sh_nxt = sh_step;
          rx_nxt = rx_shift;
          if (last_bit) begin
            rd_valid_nxt = rd_r;
            if (rd_r) rd_byte_nxt = rx_shift;
            enter = 1'b1;
            ent = (nb_r == `SMFE_NB_W'(1)) ? ST_DONE : ST_DATA;
            nb_nxt = nb_r - `SMFE_NB_W'(1);
          end
        end
      end
      ST_DONE: begin
        // Select stays low until the clock is parked at its idle level
        if (sck_idle) begin
          if (!cs_n_r) begin
            cs_n_nxt = 1'b1;
            cnt_nxt = CW'(CS_HI_CYC - 1);
          end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
          end else begin
            unique case (pop_r)
              PW_DPD, PW_HIB: begin
                cnt_nxt = CW'(ENTER_CYC - 1);
                sleep_nxt = pop_r;
                st_nxt = ST_PWAIT;
              end
              PW_WAKE: begin
                cnt_nxt = (sleep_r == PW_HIB) ? CW'(HIB_EXIT_CYC - 1) :
                          CW'(DPD_EXIT_CYC - 1);
                sleep_nxt = PW_NONE;
                st_nxt = ST_PWAIT;
              end
              PW_NONE: st_nxt = ST_IDLE;
            endcase
          end
        end
      end
      ST_PWAIT: begin
        // Execute-in-place state is kept: the device keeps its setup asleep
        if (cnt_r == '0) st_nxt = ST_IDLE;
        else cnt_nxt = cnt_r - CW'(1);
      end
      default: begin
        st_nxt = ST_IDLE;
        cs_n_nxt = 1'b1;
      end
    endcase
    if (enter) begin
      st_nxt = ent;
      unique case (ent)
        ST_CMD: begin
          sh_nxt = {cmd_r, `SMFE_ADDR_BITS'(0)};
          bits_nxt = `SMFE_BITS_W'(`SMFE_BYTE_BITS);
        end
        ST_ADDR: begin
          sh_nxt = {addr_r, `SMFE_BYTE_BITS'(0)};
          bits_nxt = `SMFE_BITS_W'(`SMFE_ADDR_BITS);
        end
        ST_XBYTE: begin
          sh_nxt = {mb_r, `SMFE_ADDR_BITS'(0)};
          bits_nxt = `SMFE_BITS_W'(`SMFE_BYTE_BITS);
        end
        ST_DUMMY: bits_nxt = {1'b0, dum_r};
        ST_DATA: begin
          bits_nxt = `SMFE_BITS_W'(`SMFE_BYTE_BITS);
          if (!rd_r) begin
            sh_nxt = {wr_byte, `SMFE_ADDR_BITS'(0)};
            wr_take_nxt = 1'b1;
          end
        end
        default: bits_nxt = bits_r;
      endcase
    end
  end

  // Sequencer and datapath registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_PWRUP;
      cnt_r <= CW'(PWRUP_CYC - 1);
      bits_r <= '0;
      sh_r <= '0;
      rx_r <= '0;
      cmd_r <= '0;
      mb_r <= '0;
      addr_r <= '0;
      dum_r <= '0;
      nb_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      cmd_r <= cmd_nxt;
      mb_r <= mb_nxt;
      addr_r <= addr_nxt;
      dum_r <= dum_nxt;
      nb_r <= nb_nxt;
    end
  end

  // Request flags, mode state and pin registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= LM_111;
      pop_r <= PW_NONE;
      sleep_r <= PW_NONE;
      has_addr_r <= 1'b0;
      mb_en_r <= 1'b0;
      rd_r <= 1'b0;
      xip_r <= 1'b0;
      cs_n_r <= 1'b1;
      wr_take_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_byte_r <= '0;
      busy_r <= 1'b1;
      io_out_r <= 4'h0;
      io_oe_r <= 4'h0;
      asleep_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      pop_r <= pop_nxt;
      sleep_r <= sleep_nxt;
      has_addr_r <= has_addr_nxt;
      mb_en_r <= mb_en_nxt;
      rd_r <= rd_nxt;
      xip_r <= xip_nxt;
      cs_n_r <= cs_n_nxt;
      wr_take_r <= wr_take_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_byte_r <= rd_byte_nxt;
      busy_r <= (st_nxt != ST_IDLE);
      io_out_r <= out_nxt;
      io_oe_r <= oe_nxt;
      asleep_r <= (sleep_nxt != PW_NONE);
    end
  end

  assign busy = busy_r;
  assign wr_take = wr_take_r;
  assign rd_valid = rd_valid_r;
  assign rd_byte = rd_byte_r;
  assign xip_active = xip_r;
  // Registered so the sleep flag leaves the block glitch-free
  assign asleep = asleep_r;
  assign cs_n = cs_n_r;
  assign io_out = io_out_r;
  assign io_oe = io_oe_r;

  pwrup_hold_a: assert property ((st_r == ST_PWRUP) |-> cs_n_r && busy_r)
    else $error("select or busy wrong during power-up wait");
  pwrup_len_a: assert property ((st_r == ST_PWRUP && cnt_r != '0) |=> st_r == ST_PWRUP)
    else $error("power-up wait cut short");
  read_float_a: assert property ((st_r == ST_DATA && rd_r && $past(st_r) == ST_DATA)
    |-> io_oe_r[1:0] == 2'h0) else $error("host drives a read lane");
  quad_cmd_a: assert property ((st_r == ST_CMD && $past(st_r) == ST_CMD && mode_r == LM_114)
    |-> io_oe_r == 4'h1) else $error("command not on lane 0 alone");
  xip_skip_a: assert property ((st_r == ST_SETUP && cnt_r == '0 && xip_r)
    |=> st_r != ST_CMD) else $error("command resent in execute in place");
  xip_enter_a: assert property ((st_r == ST_XBYTE && st_nxt != ST_XBYTE &&
    mb_r[7:4] == `SMFE_XIP_ON) |=> xip_r) else $error("mode byte A did not enter");
  dpd_exit_a: assert property ((st_r == ST_DONE && st_nxt == ST_PWAIT && pop_r == PW_WAKE &&
    sleep_r == PW_DPD) |=> cnt_r == CW'(DPD_EXIT_CYC - 1)) else $error("deep sleep exit wait");
  hib_exit_a: assert property ((st_r == ST_DONE && st_nxt == ST_PWAIT && pop_r == PW_WAKE &&
    sleep_r == PW_HIB) |=> cnt_r == CW'(HIB_EXIT_CYC - 1)) else $error("hibernate exit wait");
  cs_gap_a: assert property ($rose(cs_n_r) |-> cs_n_r [*7])
    else $error("select high pulse too short");
  sck_park_a: assert property ($rose(cs_n_r) |-> sck == SPI_MODE3)
    else $error("clock not at idle level at deselect");
  msb_first_a: assert property ((st_r == ST_SETUP && st_nxt == ST_CMD)
    |=> sh_r[31:24] == $past(cmd_r)) else $error("command not loaded msb first");

endmodule // smfe_host

// ---- hw/smfe_defines.svh ----
`ifndef SMFE_DEFINES_SVH
`define SMFE_DEFINES_SVH

// Clock and bit framing
`define SMFE_CLK_MHZ 125
`define SMFE_CLK_NS 8
`define SMFE_BYTE_BITS 8
`define SMFE_ADDR_BITS 24
`define SMFE_SR_W 32

// Device timing figures, in their printed units
`define SMFE_PWRUP_US 250
`define SMFE_ENTER_US 3
`define SMFE_DPD_EXIT_US 400
`define SMFE_HIB_EXIT_US 450
`define SMFE_CS_HI_NS 50

// Mode byte upper nibbles
`define SMFE_XIP_ON 4'hA
`define SMFE_XIP_OFF 4'hF

// Counter widths for the long waits, bit count, dummy cycles and byte count
`define SMFE_CNT_W 17
`define SMFE_BITS_W 6
`define SMFE_DUM_W 5
`define SMFE_NB_W 16

`endif

// ---- hw/smfe_pkg.sv ----
package smfe_pkg;

  // Lane usage, command-address-data
  typedef enum logic [2:0] {
    LM_111 = 3'h0, LM_112 = 3'h1, LM_122 = 3'h2, LM_222 = 3'h3,
    LM_114 = 3'h4, LM_144 = 3'h5, LM_444 = 3'h6
  } smfe_lane_t;

  // Power request attached to an instruction, and the sleep state held
  typedef enum logic [1:0] {
    PW_NONE = 2'h0, PW_DPD = 2'h1, PW_HIB = 2'h2, PW_WAKE = 2'h3
  } smfe_pwr_t;

  // Instruction components
  typedef enum logic [1:0] {CP_CMD = 2'h0, CP_ADDR = 2'h1, CP_DATA = 2'h2} smfe_comp_t;

  // Gray codes along power-up, idle, setup, cmd, addr, mode byte, dummy, data, done
  typedef enum logic [3:0] {
    ST_PWRUP = 4'h0, ST_IDLE = 4'h1, ST_SETUP = 4'h3, ST_CMD = 4'h2,
    ST_ADDR = 4'h6, ST_XBYTE = 4'h7, ST_DUMMY = 4'h5, ST_DATA = 4'h4,
    ST_DONE = 4'hC, ST_PWAIT = 4'hD
  } smfe_state_t;

  // Number of lanes a component uses in a given mode
  function automatic logic [2:0] smfe_lane_w(smfe_lane_t m, smfe_comp_t c);
    logic [2:0] w;
    w = 3'h1;
    unique case (c)
      CP_CMD: w = (m == LM_444) ? 3'h4 : (m == LM_222) ? 3'h2 : 3'h1;
      CP_ADDR: w = (m == LM_444 || m == LM_144) ? 3'h4 :
                   (m == LM_222 || m == LM_122) ? 3'h2 : 3'h1;
      default: w = (m == LM_111) ? 3'h1 :
                   (m == LM_112 || m == LM_122 || m == LM_222) ? 3'h2 : 3'h4;
    endcase
    return w;
  endfunction

endpackage

// ---- hw/smfe_sck_gen.sv ----
`timescale 1ns/1ps
// Serial clock divider; idles at the level of the chosen clock mode
module smfe_sck_gen #(
  parameter int HALF = 4,
  parameter bit MODE3 = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic sck,
  output logic rise_evt,
  output logic sck_idle
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic IDLE_LVL = MODE3;

  logic [CW-1:0] cnt_r;
  logic sck_r;
  logic rise_r;
  wire half_done = (cnt_r == CW'(HALF - 1));
  wire parked = !run && (sck_r == IDLE_LVL);

  // Keeps toggling after run drops until the idle level is back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      sck_r <= IDLE_LVL;
      rise_r <= 1'b0;
    end else begin
      rise_r <= !parked && half_done && !sck_r;
      if (parked || half_done) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
      if (!parked && half_done) begin
        sck_r <= !sck_r;
      end
    end
  end

  assign sck = sck_r;
  assign rise_evt = rise_r;
  assign sck_idle = parked;

  // Sampling edge pulse marks exactly a low-to-high transition
  rise_mark_a: assert property (@(posedge clk) disable iff (!nrst)
    rise_r |-> sck_r && !$past(sck_r)) else $error("rise pulse without rising clock");

endmodule // smfe_sck_gen

// ---- verification/smfe_dev_model.sv ----
`timescale 1ns/1ps
// Behavioural memory device facing the host's serial lanes
module smfe_dev_model
  import smfe_pkg::*;
(
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io,
  input wire smfe_lane_t lane_mode,
  input wire logic skip_cmd,
  input wire logic has_addr,
  input wire logic [5:0] gap,
  input wire logic is_read,
  output logic [3:0] dev_out,
  output logic [3:0] dev_oe,
  output logic [7:0] cmd_r,
  output logic [23:0] addr_r,
  output logic [7:0] wdat_r,
  output int nwr
);
  int k, bi, wc, wa, wd, ec, ea, ed;

  function automatic logic [3:0] take(int w);
    return (w == 1) ? {3'h0, io[0]} : (w == 2) ? {2'h0, io[1:0]} : io;
  endfunction

  // Read bytes count up from A5 so every lane carries changing bits
  function automatic logic [3:0] lanes(int n);
    logic [7:0] v;
    v = (8'hA5 + 8'((n * wd) / 8)) << ((n * wd) % 8);
    return (wd == 1) ? {2'h0, v[7], 1'h0} : (wd == 2) ? {2'h0, v[7:6]} : v[7:4];
  endfunction

  // Lanes per component and the edge at which each phase starts
  always_comb begin
    wc = (lane_mode == LM_444) ? 4 : (lane_mode == LM_222) ? 2 : 1;
    wa = (lane_mode inside {LM_144, LM_444}) ? 4 : (lane_mode inside {LM_122, LM_222}) ? 2 : 1;
    wd = (lane_mode == LM_111) ? 1 : (lane_mode inside {LM_112, LM_122, LM_222}) ? 2 : 4;
    ec = skip_cmd ? 0 : 8 / wc;
    ea = ec + (has_addr ? 24 / wa : 0);
    ed = ea + gap;
  end

  // Powers up deselected, nothing driven
  initial begin
    nwr = 0;
    dev_oe = 4'h0;
  end

  // Inputs sampled on rising clock while selected; a select rise resets the decoder
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      k <= 0;
      bi <= 0;
    end else begin
      k <= k + 1;
      if (k < ec) begin
        cmd_r <= 8'((cmd_r << wc) | take(wc));
      end else if (k < ea) begin
        addr_r <= 24'((addr_r << wa) | take(wa));
      end else if (k >= ed && !is_read) begin
        wdat_r <= 8'((wdat_r << wd) | take(wd));
        bi <= (bi + wd == 8) ? 0 : bi + wd;
        if (bi + wd == 8) nwr <= nwr + 1;
      end
    end
  end

  // Read data launched from falling clock; lanes float when writing or deselected
  always @(negedge sck or posedge cs_n) begin
    if (cs_n || !is_read || k < ed) begin
      dev_oe <= 4'h0;
    end else begin
      dev_oe <= (wd == 1) ? 4'h2 : (wd == 2) ? 4'h3 : 4'hF;
      dev_out <= lanes(k - ed);
    end
  end
endmodule // smfe_dev_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import smfe_pkg::*;
  logic clk, flt = 1'b0, xp = 1'b0, skip = 1'b0, nrst = 1'b0, start = 1'b0;
  logic has_addr = 1'b0, send_mode_byte = 1'b0, is_read = 1'b0, wp_level = 1'b1;
  logic [7:0] cmd = 8'h00, mode_byte = 8'h00, wr_byte = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [4:0] dummy_cyc = 5'h00;
  logic [5:0] gap = 6'h00;
  logic [15:0] nbytes = 16'h0000;
  smfe_lane_t lane_mode = LM_111;
  smfe_pwr_t pwr_op = PW_NONE;
  logic busy, wr_take, rd_valid, xip_active, asleep, sck, cs_n;
  logic [7:0] rd_byte, cmd_r, wdat_r;
  logic [23:0] addr_r;
  logic [3:0] io_out, io_oe, io_in, dev_out, dev_oe;
  int num_errors = 0, n_checks = 0, nwr, hi = 0, bc;
  logic [7:0] rq[$];

  smfe_host #(.PWRUP_CYC(20), .DPD_EXIT_CYC(30), .HIB_EXIT_CYC(40)) smfe_host_i (
    .clk, .nrst, .start, .cmd, .lane_mode, .has_addr, .addr, .send_mode_byte, .mode_byte,
    .dummy_cyc, .nbytes, .is_read, .pwr_op, .wp_level, .wr_byte, .busy, .wr_take,
    .rd_valid, .rd_byte, .xip_active, .asleep, .sck, .cs_n, .io_out, .io_oe, .io_in);
  smfe_dev_model smfe_dev_model_i (.sck, .cs_n, .io(io_in), .lane_mode, .skip_cmd(skip),
    .has_addr, .gap, .is_read, .dev_out, .dev_oe, .cmd_r, .addr_r, .wdat_r, .nwr);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A released lane toggles, so a stale level never passes for data
  always @(posedge clk) flt <= ~flt;
  always_comb for (int i = 0; i < 4; i++) io_in[i] = io_oe[i] ? io_out[i] : dev_oe[i] ? dev_out[i] : flt;

  task automatic chk_v(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int lo, input int up, input int g);
    n_checks++;
    if (g < lo || g > up) begin
      num_errors++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, up, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Select gap, parked clock between frames, no lane driven from both ends
  always @(negedge clk) begin
    hi <= cs_n ? hi + 1 : 0;
    if (nrst && !cs_n && hi != 0) chk_n("select gap", 7, 1000000, hi);
    if (nrst && cs_n && sck !== 1'b0) chk_v("idle clock", 0, sck);
    if (nrst && (io_oe & dev_oe) != 4'h0) chk_v("lane clash", 0, io_oe & dev_oe);
  end

  // One instruction; the next write byte follows each take pulse
  task automatic run(input logic [7:0] c, input smfe_lane_t m, input logic [23:0] a,
      input logic smb, input logic [7:0] mb, input logic rd, input logic [15:0] n,
      input smfe_pwr_t p);
    int t;
    logic tk;
    @(posedge clk);
    cmd <= c;
    lane_mode <= m;
    has_addr <= n != 16'h0000;
    addr <= a;
    send_mode_byte <= smb;
    mode_byte <= mb;
    dummy_cyc <= rd ? 5'h08 : 5'h00;
    gap <= (rd ? 6'h08 : 6'h00) + (smb ? 6'h08 : 6'h00);
    nbytes <= n;
    is_read <= rd;
    pwr_op <= p;
    wr_byte <= 8'h3C;
    skip <= xp;
    start <= 1'b1;
    rq = {};
    bc = 0;
    tk = 1'b0;
    for (t = 0; t < 3000; t++) begin
      @(posedge clk);
      start <= 1'b0;
      if (tk) wr_byte <= wr_byte + 8'h11;
      @(negedge clk);
      tk = wr_take;
      if (rd_valid) rq.push_back(rd_byte);
      if (busy === 1'b0) break;
      bc++;
    end
    if (t == 3000) begin
      chk_v("busy timeout", 0, 1);
      close_out;
    end
    if (smb && mb[7:4] == 4'hA) xp = 1'b1;
    if (smb && mb[7:4] == 4'hF) xp = 1'b0;
  endtask

  task automatic t_reset;
    int t;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_v("select in reset", 1, cs_n);
    chk_v("enables in reset", 0, io_oe);
    @(posedge clk);
    nrst <= 1'b1;
    for (t = 0; t < 100 && busy !== 1'b0; t++) begin
      @(negedge clk);
      chk_v("select at power-up", 1, cs_n);
    end
    chk_n("power-up wait", 20, 40, t);
    if (t == 100) close_out;
  endtask

  // Every lane mode, a two-byte write then a two-byte read
  task automatic t_modes;
    int w;
    for (int i = 0; i < 7; i++) begin
      w = nwr;
      run(8'h02, smfe_lane_t'(i), 24'h5A0000 + i, 1'b0, 8'h00, 1'b0, 16'h0002, PW_NONE);
      chk_v("write cmd", 8'h02, cmd_r);
      chk_v("write addr", 24'h5A0000 + i, addr_r);
      chk_v("last write byte", 8'h4D, wdat_r);
      chk_n("bytes written", w + 2, w + 2, nwr);
      run(8'h0B, smfe_lane_t'(i), 24'hC30000 + i, 1'b0, 8'h00, 1'b1, 16'h0002, PW_NONE);
      chk_v("read addr", 24'hC30000 + i, addr_r);
      chk_v("read count", 2, rq.size());
      chk_v("read byte 0", 8'hA5, rq[0]);
      chk_v("read byte 1", 8'hA6, rq[1]);
    end
  endtask

  task automatic t_xip;
    run(8'h0B, LM_111, 24'h000100, 1'b1, 8'hA3, 1'b1, 16'h0001, PW_NONE);
    chk_v("xip on", 1, xip_active);
    run(8'hEE, LM_111, 24'h000200, 1'b0, 8'h00, 1'b1, 16'h0001, PW_NONE);
    chk_v("xip cmd skipped", 8'h0B, cmd_r);
    chk_v("xip addr", 24'h000200, addr_r);
    chk_v("xip read", 8'hA5, rq[0]);
    run(8'hEE, LM_111, 24'h000300, 1'b1, 8'hF5, 1'b0, 16'h0001, PW_NONE);
    chk_v("xip write", 8'h3C, wdat_r);
    chk_v("xip off", 0, xip_active);
    run(8'h03, LM_111, 24'h000400, 1'b0, 8'h00, 1'b1, 16'h0001, PW_NONE);
    chk_v("cmd after xip", 8'h03, cmd_r);
  endtask

  // Protect level follows the pin input in single-lane use only
  task automatic t_wp;
    chk_v("protect driven", 1, io_oe[2]);
    chk_v("protect high", 1, io_out[2]);
    @(posedge clk);
    wp_level <= 1'b0;
    repeat (3) @(negedge clk);
    chk_v("protect low", 0, io_out[2]);
    run(8'h02, LM_444, 24'h000010, 1'b0, 8'h00, 1'b0, 16'h0001, PW_NONE);
    chk_v("protect released", 0, io_oe[2]);
  endtask

  // Exit waits differ by exactly the gap between the two exit parameters
  task automatic t_pwr;
    int bd, nw;
    nw = nwr;
    run(8'hB9, LM_111, 24'h000000, 1'b0, 8'h00, 1'b0, 16'h0000, PW_DPD);
    chk_v("asleep deep", 1, asleep);
    chk_n("deep entry", 382, 3000, bc);
    chk_v("sleep cmd", 8'hB9, cmd_r);
    run(8'hAB, LM_111, 24'h000000, 1'b0, 8'h00, 1'b0, 16'h0000, PW_WAKE);
    chk_v("awake deep", 0, asleep);
    bd = bc;
    run(8'hB8, LM_111, 24'h000000, 1'b0, 8'h00, 1'b0, 16'h0000, PW_HIB);
    chk_v("asleep hib", 1, asleep);
    chk_n("hib entry", 382, 3000, bc);
    run(8'hAB, LM_111, 24'h000000, 1'b0, 8'h00, 1'b0, 16'h0000, PW_WAKE);
    chk_v("awake hib", 0, asleep);
    chk_n("exit wait gap", 10, 10, bc - bd);
    chk_n("data kept asleep", nw, nw, nwr);
  endtask

  initial begin
    t_reset;
    t_modes;
    t_xip;
    t_wp;
    t_pwr;
    close_out;
  end
endmodule // testbench
